//--- inc/tick_if.sv
`default_nettype none
interface tick_if;
  logic sys_tick;
  logic ext_tick;
  modport source (output sys_tick, output ext_tick);
  modport sink (input sys_tick, input ext_tick);
endinterface
`default_nettype wire

//--- inc/timer_two_pkg.sv
`default_nettype none
package timer_two_pkg;
  // Register addresses on the special-function register bus.
  localparam logic [7:0] ADDR_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
  // Bit positions in timer_two_control.
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_RESERVED = 1;
  localparam int BIT_EXT_CLK = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Prescaler ratios: system clock by twelve, external clock by eight.
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
endpackage
`default_nettype wire

//--- rtl/reload_capture_timer_two.sv
// How it works
// - High flag sets when the upper byte rolls from 0xFF to 0x00.
// - In 16-bit mode high flag sets when the count wraps 0xFFFF to 0x0000.
// - With this timer's interrupt enabled, a set high flag requests an interrupt.
// - Hardware never clears either overflow flag; software clears them by writing control.
// - Low flag sets on every lower byte rollover, in any mode.
// - Low interrupt enable plus timer interrupt enable gives a request per low overflow.
// - Capture mode copies the 16-bit count into reloads on pin falling edge.
// - Split select 0 gives one 16-bit reload counter, 1 gives two 8-bit.
// - Run bit gates counting; in split mode it gates the upper byte only.
// - In split mode the lower byte always counts.
// - External select 0 counts the system clock divided by twelve.
// - External select 1 counts the external clock divided by eight, resynchronised.
// - In either mode per-byte selects pick the undivided system clock or the shared source; the upper select only acts in split mode.
// - Lower reload register feeds the lower byte on reload.
// - In capture mode the lower reload register holds the captured lower byte.
// - Upper reload register feeds the upper byte, or holds its capture.
// - Count registers form one 16-bit counter, or two 8-bit timers when split.
`default_nettype none
module reload_capture_timer_two (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_timer_irq_enable,
  input wire logic i_upper_byte_clock_select,
  input wire logic i_lower_byte_clock_select,
  input wire logic i_ext_clk,
  input wire logic i_capture_pin,
  output logic o_irq,
  output logic o_high_overflow_flag,
  output logic o_low_overflow_flag
);
  function automatic logic [7:0] byte_inc(input logic [7:0] value);
    byte_inc = 8'(value + 8'h01);
  endfunction

  function automatic logic [7:0] sfr_byte(input logic wr, input logic [7:0] wdata,
                                          input logic [7:0] held);
    sfr_byte = wr ? wdata : held;
  endfunction

  tick_if ticks ();

  tick_source u_tick_source (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_ext_clk(i_ext_clk),
    .ticks(ticks.source)
  );

  logic high_flag_reg;
  logic low_flag_reg;
  logic low_irq_en_reg;
  logic capture_en_reg;
  logic split_reg;
  logic run_reg;
  logic ext_sel_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic [7:0] count_low_reg;
  logic [7:0] count_high_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic pin_prev_reg;

  // Register decode.
  wire wr_control = i_sfr_wr && (i_sfr_addr == timer_two_pkg::ADDR_CONTROL);
  wire wr_reload_low = i_sfr_wr && (i_sfr_addr == timer_two_pkg::ADDR_RELOAD_LOW);
  wire wr_reload_high = i_sfr_wr && (i_sfr_addr == timer_two_pkg::ADDR_RELOAD_HIGH);
  wire wr_count_low = i_sfr_wr && (i_sfr_addr == timer_two_pkg::ADDR_COUNT_LOW);
  wire wr_count_high = i_sfr_wr && (i_sfr_addr == timer_two_pkg::ADDR_COUNT_HIGH);

  // Counting sources. A per-byte select of 1 bypasses the prescaler for that byte.
  wire base_tick = ext_sel_reg ? ticks.ext_tick : ticks.sys_tick;
  wire low_tick = i_lower_byte_clock_select ? 1'b1 : base_tick;
  wire high_tick = i_upper_byte_clock_select ? 1'b1 : base_tick;

  // Counter stepping and overflow detection.
  wire low_step = split_reg ? low_tick : (run_reg && low_tick);
  wire high_split_step = split_reg && run_reg && high_tick;
  wire low_at_max = (count_low_reg == timer_two_pkg::BYTE_MAX);
  wire high_at_max = (count_high_reg == timer_two_pkg::BYTE_MAX);
  wire low_wrap = low_step && low_at_max;
  wire full_wrap = !split_reg && low_wrap && high_at_max;
  wire high_wrap = split_reg ? (high_split_step && high_at_max) : full_wrap;
  wire high_inc = split_reg ? high_split_step : low_wrap;
  wire low_reload = split_reg ? low_wrap : full_wrap;
  wire reload_mode = !capture_en_reg;
  wire capture_evt = capture_en_reg && pin_prev_reg && !i_capture_pin;

  // Next values. Software writes to a count byte win over the counter step.
  // In capture mode a wrap rolls to zero, because the reload pair holds the last capture.
  wire [7:0] count_low_step = (low_reload && reload_mode) ? reload_low_reg :
                              low_step ? byte_inc(count_low_reg) : count_low_reg;
  wire [7:0] count_high_step = (high_wrap && reload_mode) ? reload_high_reg :
                               high_inc ? byte_inc(count_high_reg) : count_high_reg;
  wire [7:0] count_low_next = sfr_byte(wr_count_low, i_sfr_wdata, count_low_step);
  wire [7:0] count_high_next = sfr_byte(wr_count_high, i_sfr_wdata, count_high_step);

  // A capture outranks a software write to the reload pair in the same cycle.
  wire [7:0] reload_low_next = capture_evt ? count_low_reg :
                               sfr_byte(wr_reload_low, i_sfr_wdata, reload_low_reg);
  wire [7:0] reload_high_next = capture_evt ? count_high_reg :
                                sfr_byte(wr_reload_high, i_sfr_wdata, reload_high_reg);

  // Flags are sticky: a hardware set beats a software clear in the same cycle.
  wire high_flag_hold = wr_control ? i_sfr_wdata[timer_two_pkg::BIT_HIGH_FLAG] : high_flag_reg;
  wire low_flag_hold = wr_control ? i_sfr_wdata[timer_two_pkg::BIT_LOW_FLAG] : low_flag_reg;
  wire high_flag_next = high_wrap || capture_evt || high_flag_hold;
  wire low_flag_next = low_wrap || low_flag_hold;
  wire low_irq_en_next = wr_control ? i_sfr_wdata[timer_two_pkg::BIT_LOW_IRQ_EN] : low_irq_en_reg;

  wire irq_next = i_timer_irq_enable &&
                  (high_flag_next || (low_flag_next && low_irq_en_next));

  wire [7:0] control_read = {high_flag_reg, low_flag_reg, low_irq_en_reg, capture_en_reg,
                             split_reg, run_reg, 1'b0, ext_sel_reg};
  // Reads have no side effects and the count bytes are not latched together,
  // so software should read the 16-bit count while the timer is stopped.
  wire [7:0] rdata_next =
    (i_sfr_addr == timer_two_pkg::ADDR_CONTROL) ? control_read :
    (i_sfr_addr == timer_two_pkg::ADDR_RELOAD_LOW) ? reload_low_reg :
    (i_sfr_addr == timer_two_pkg::ADDR_RELOAD_HIGH) ? reload_high_reg :
    (i_sfr_addr == timer_two_pkg::ADDR_COUNT_LOW) ? count_low_reg :
    (i_sfr_addr == timer_two_pkg::ADDR_COUNT_HIGH) ? count_high_reg :
    timer_two_pkg::UNMAPPED_READ;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      high_flag_reg <= 1'b0;
      low_flag_reg <= 1'b0;
      low_irq_en_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      high_flag_reg <= high_flag_next;
      low_flag_reg <= low_flag_next;
      low_irq_en_reg <= low_irq_en_next;
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      capture_en_reg <= 1'b0;
      split_reg <= 1'b0;
      run_reg <= 1'b0;
      ext_sel_reg <= 1'b0;
    end
    else if (wr_control)
    begin
      capture_en_reg <= i_sfr_wdata[timer_two_pkg::BIT_CAPTURE_EN];
      split_reg <= i_sfr_wdata[timer_two_pkg::BIT_SPLIT];
      run_reg <= i_sfr_wdata[timer_two_pkg::BIT_RUN];
      ext_sel_reg <= i_sfr_wdata[timer_two_pkg::BIT_EXT_CLK];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      reload_low_reg <= timer_two_pkg::RESET_BYTE;
      reload_high_reg <= timer_two_pkg::RESET_BYTE;
      count_low_reg <= timer_two_pkg::RESET_BYTE;
      count_high_reg <= timer_two_pkg::RESET_BYTE;
    end
    else
    begin
      reload_low_reg <= reload_low_next;
      reload_high_reg <= reload_high_next;
      count_low_reg <= count_low_next;
      count_high_reg <= count_high_next;
    end
  end

  // The pin history is cleared at reset so a low pin does not fake an edge afterwards.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      pin_prev_reg <= 1'b0;
      rdata_reg <= timer_two_pkg::UNMAPPED_READ;
    end
    else
    begin
      pin_prev_reg <= i_capture_pin;
      rdata_reg <= rdata_next;
    end
  end

  assign o_sfr_rdata = rdata_reg;
  assign o_irq = irq_reg;
  assign o_high_overflow_flag = high_flag_reg;
  assign o_low_overflow_flag = low_flag_reg;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  a_full_wrap_reload: assert property (
    full_wrap && reload_mode && !wr_count_low && !wr_count_high
    |=> high_flag_reg && low_flag_reg && count_high_reg == $past(reload_high_reg)
        && count_low_reg == $past(reload_low_reg))
    else $error("16-bit wrap did not flag and reload");
  a_split_high_wrap: assert property (
    split_reg && run_reg && high_tick && high_at_max && !wr_count_high && reload_mode
    |=> high_flag_reg && count_high_reg == $past(reload_high_reg))
    else $error("upper byte wrap did not flag and reload");
  a_low_wrap_flag: assert property (low_wrap |=> low_flag_reg)
    else $error("lower byte wrap did not set low flag");
  a_flag_stays_set: assert property (
    !wr_control
    |=> (!$past(high_flag_reg) || high_flag_reg) && (!$past(low_flag_reg) || low_flag_reg))
    else $error("overflow flag cleared without a control write");
  a_irq_from_flags: assert property (
    $past(i_timer_irq_enable) && (high_flag_reg || (low_flag_reg && low_irq_en_reg)) |-> o_irq)
    else $error("interrupt request missing for a set flag");
  a_irq_gated: assert property (!$past(i_timer_irq_enable) |-> !o_irq)
    else $error("interrupt request while timer interrupt disabled");
  a_capture_copy: assert property (
    capture_evt |=> reload_low_reg == $past(count_low_reg)
                    && reload_high_reg == $past(count_high_reg) && high_flag_reg)
    else $error("capture did not copy the count");
  a_split_low_free: assert property (
    split_reg && !run_reg && low_tick && !low_at_max && !wr_count_low
    |=> count_low_reg == byte_inc($past(count_low_reg)))
    else $error("split lower byte stopped with run bit low");
  a_stopped_hold: assert property (
    !run_reg && !split_reg && !wr_count_low && !wr_count_high [*2]
    |-> $stable(count_low_reg) && $stable(count_high_reg))
    else $error("16-bit counter moved while stopped");
  a_reserved_zero: assert property (
    $past(i_sfr_addr) == timer_two_pkg::ADDR_CONTROL
    |-> o_sfr_rdata[timer_two_pkg::BIT_RESERVED] == 1'b0)
    else $error("reserved control bit read as one");

  // Request, carry and register-path checks.
  a_irq_quiet: assert property (
    !high_flag_reg && !(low_flag_reg && low_irq_en_reg) |-> !o_irq)
    else $error("interrupt request with no enabled flag set");

  a_low_carry: assert property (
    !split_reg && low_wrap && !high_at_max && !wr_count_high
    |=> count_high_reg == byte_inc($past(count_high_reg)))
    else $error("lower byte wrap did not carry into the upper byte");

  a_split_high_stop: assert property (
    split_reg && !run_reg && !wr_count_high |=> $stable(count_high_reg))
    else $error("split upper byte moved with run bit low");

  a_split_low_reload: assert property (
    split_reg && low_wrap && reload_mode && !wr_count_low
    |=> count_low_reg == $past(reload_low_reg))
    else $error("split lower byte did not reload on wrap");

  a_reload_idle: assert property (
    !capture_evt && !wr_reload_low && !wr_reload_high
    |=> $stable(reload_low_reg) && $stable(reload_high_reg))
    else $error("reload register changed without a write or capture");

  a_reload_write: assert property (
    wr_reload_low && !capture_evt |=> reload_low_reg == $past(i_sfr_wdata))
    else $error("lower reload write did not land");

  a_upper_reload_write: assert property (
    wr_reload_high && !capture_evt |=> reload_high_reg == $past(i_sfr_wdata))
    else $error("upper reload write did not land");

  a_count_write: assert property (wr_count_low |=> count_low_reg == $past(i_sfr_wdata))
    else $error("count write did not land");

  a_control_write: assert property (
    wr_control |=> split_reg == $past(i_sfr_wdata[timer_two_pkg::BIT_SPLIT])
                   && run_reg == $past(i_sfr_wdata[timer_two_pkg::BIT_RUN]))
    else $error("control write did not land");

  a_sys_source: assert property (
    !split_reg && !ext_sel_reg && !i_lower_byte_clock_select && !ticks.sys_tick
    && !wr_count_low |=> $stable(count_low_reg))
    else $error("counter stepped without a system tick");

  a_ext_source: assert property (
    !split_reg && ext_sel_reg && !i_lower_byte_clock_select && !ticks.ext_tick
    && !wr_count_low |=> $stable(count_low_reg))
    else $error("counter stepped without an external tick");

  c_capture: cover property (capture_evt ##1 o_irq);
  c_full_wrap: cover property (full_wrap);
  c_split_both_wrap: cover property (split_reg && low_wrap && high_wrap);
  c_low_irq: cover property (low_flag_reg && low_irq_en_reg && o_irq);
  c_ext_step: cover property (ext_sel_reg && ticks.ext_tick && low_step);
endmodule
`default_nettype wire

//--- rtl/tick_source.sv
`default_nettype none
module tick_source (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ext_clk,
  tick_if.source ticks
);
  logic [3:0] sys_cnt_reg;
  logic [2:0] ext_cnt_reg;
  logic ext_prev_reg;
  logic sys_tick_reg;
  logic ext_tick_reg;
  logic [3:0] tick_gap_reg;

  wire sys_last = (sys_cnt_reg == timer_two_pkg::SYS_DIV_LAST);
  wire ext_rise = i_ext_clk && !ext_prev_reg;
  wire ext_last = (ext_cnt_reg == timer_two_pkg::EXT_DIV_LAST);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      sys_cnt_reg <= 4'h0;
      sys_tick_reg <= 1'b0;
    end
    else
    begin
      sys_cnt_reg <= sys_last ? 4'h0 : 4'(sys_cnt_reg + 4'h1);
      sys_tick_reg <= sys_last;
    end
  end

  // The external edge is counted here and re-emitted as a one-cycle pulse of the system clock.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      ext_prev_reg <= 1'b0;
      ext_cnt_reg <= 3'h0;
      ext_tick_reg <= 1'b0;
    end
    else
    begin
      ext_prev_reg <= i_ext_clk;
      if (ext_rise)
        ext_cnt_reg <= 3'(ext_cnt_reg + 3'h1);
      ext_tick_reg <= ext_rise && ext_last;
    end
  end

  assign ticks.sys_tick = sys_tick_reg;
  assign ticks.ext_tick = ext_tick_reg;

  // Cycles since the last system tick, kept only for the period check below.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      tick_gap_reg <= 4'h0;
    else
      tick_gap_reg <= sys_tick_reg ? 4'h1 : 4'(tick_gap_reg + 4'h1);
  end

  a_sys_tick_period: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    sys_tick_reg == (tick_gap_reg == 4'(timer_two_pkg::SYS_DIV)))
    else $error("system tick period is not twelve cycles");
  a_ext_tick_cause: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    ext_tick_reg |-> $past(ext_rise) && $past(ext_cnt_reg) == timer_two_pkg::EXT_DIV_LAST)
    else $error("external tick without eighth external edge");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk, i_srst, i_sfr_wr, o_irq, o_high_overflow_flag, o_low_overflow_flag;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, v;
  logic i_timer_irq_enable, i_upper_byte_clock_select, i_lower_byte_clock_select;
  logic i_ext_clk, i_capture_pin;
  int fail_count = 0;
  int n_tests = 0;
  reload_capture_timer_two uut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_timer_irq_enable(i_timer_irq_enable),
    .i_upper_byte_clock_select(i_upper_byte_clock_select),
    .i_lower_byte_clock_select(i_lower_byte_clock_select), .i_ext_clk(i_ext_clk),
    .i_capture_pin(i_capture_pin), .o_irq(o_irq),
    .o_high_overflow_flag(o_high_overflow_flag), .o_low_overflow_flag(o_low_overflow_flag));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rng(input string nm, input logic [7:0] lo, input logic [7:0] hi);
    n_tests++;
    if ((v >= lo && v <= hi) !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_sfr_wr = 1'b0;
  endtask
  // Read data is registered, so it is taken one edge after the address.
  task automatic rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    #1;
    i_sfr_addr = a;
    @(posedge i_ref_clk);
    #1;
    v = o_sfr_rdata;
  endtask
  task automatic load(input logic [7:0] rl, input logic [7:0] rh, input logic [7:0] cl,
                      input logic [7:0] ch);
    wr(timer_two_pkg::ADDR_RELOAD_LOW, rl);
    wr(timer_two_pkg::ADDR_RELOAD_HIGH, rh);
    wr(timer_two_pkg::ADDR_COUNT_LOW, cl);
    wr(timer_two_pkg::ADDR_COUNT_HIGH, ch);
  endtask
  task automatic wait_flag(input bit high, input int lim);
    int k;
    k = 0;
    while ((high ? o_high_overflow_flag : o_low_overflow_flag) !== 1'b1 && k < lim)
    begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
    chk("overflow flag in time", 8'h01, {7'h00, k < lim});
  endtask
  task automatic t_reset;
    logic [7:0] addrs [6];
    addrs = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
    foreach (addrs[i])
    begin
      rd(addrs[i]);
      chk("reset value", 8'h00, v);
    end
    wr(timer_two_pkg::ADDR_CONTROL, 8'h02);
    rd(timer_two_pkg::ADDR_CONTROL);
    chk("reserved bit", 8'h00, v);
  endtask
  task automatic t_wrap16;
    i_lower_byte_clock_select = 1'b1;
    load(8'h34, 8'h12, 8'hfe, 8'hff);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h04);
    wait_flag(1'b1, 50);
    wr(timer_two_pkg::ADDR_CONTROL, 8'hc0);
    rd(timer_two_pkg::ADDR_COUNT_HIGH);
    chk("reloaded count_high", 8'h12, v);
    rd(timer_two_pkg::ADDR_COUNT_LOW);
    rng("reloaded count_low", 8'h34, 8'h3c);
    chk("low flag on wrap", 8'h01, {7'h00, o_low_overflow_flag});
    chk("irq on high flag", 8'h01, {7'h00, o_irq});
    repeat (20) @(posedge i_ref_clk);
    #1;
    chk("high flag held", 8'h01, {7'h00, o_high_overflow_flag});
    i_timer_irq_enable = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk("irq masked", 8'h00, {7'h00, o_irq});
    i_timer_irq_enable = 1'b1;
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk("flags cleared", 8'h00, {6'h00, o_high_overflow_flag, o_low_overflow_flag});
  endtask
  task automatic t_low16;
    load(8'h00, 8'h00, 8'hfe, 8'h00);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h04);
    wait_flag(1'b0, 50);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h40);
    rd(timer_two_pkg::ADDR_COUNT_HIGH);
    chk("carry into count_high", 8'h01, v);
    chk("no high flag", 8'h00, {7'h00, o_high_overflow_flag});
    chk("low irq disabled", 8'h00, {7'h00, o_irq});
    wr(timer_two_pkg::ADDR_CONTROL, 8'h60);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk("low irq enabled", 8'h01, {7'h00, o_irq});
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_split;
    i_upper_byte_clock_select = 1'b1;
    load(8'h80, 8'h11, 8'hfe, 8'h22);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h08);
    wait_flag(1'b0, 50);
    rd(timer_two_pkg::ADDR_COUNT_HIGH);
    chk("upper idle when stopped", 8'h22, v);
    rd(timer_two_pkg::ADDR_COUNT_LOW);
    rng("lower reload in split", 8'h80, 8'h90);
    chk("no high flag in split", 8'h00, {7'h00, o_high_overflow_flag});
    wr(timer_two_pkg::ADDR_COUNT_HIGH, 8'hff);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h0c);
    wait_flag(1'b1, 50);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h08);
    rd(timer_two_pkg::ADDR_COUNT_HIGH);
    rng("upper reload in split", 8'h11, 8'h19);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    i_upper_byte_clock_select = 1'b0;
    i_lower_byte_clock_select = 1'b0;
  endtask
  task automatic t_sources;
    load(8'h00, 8'h00, 8'h00, 8'h00);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h04);
    repeat (120) @(posedge i_ref_clk);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    rd(timer_two_pkg::ADDR_COUNT_LOW);
    rng("system clock by twelve", 8'h09, 8'h0b);
    wr(timer_two_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h05);
    repeat (64)
    begin
      @(posedge i_ref_clk);
      #1;
      i_ext_clk = 1'b1;
      @(posedge i_ref_clk);
      #1;
      i_ext_clk = 1'b0;
    end
    repeat (4) @(posedge i_ref_clk);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h01);
    rd(timer_two_pkg::ADDR_COUNT_LOW);
    chk("external clock by eight", 8'h08, v);
  endtask
  task automatic t_capture;
    load(8'h00, 8'h00, 8'hcd, 8'hab);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h10);
    @(posedge i_ref_clk);
    #1;
    i_capture_pin = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    i_capture_pin = 1'b1;
    rd(timer_two_pkg::ADDR_RELOAD_LOW);
    chk("captured low", 8'hcd, v);
    rd(timer_two_pkg::ADDR_RELOAD_HIGH);
    chk("captured high", 8'hab, v);
    chk("capture flag", 8'h01, {7'h00, o_high_overflow_flag});
    chk("capture irq", 8'h01, {7'h00, o_irq});
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    wr(timer_two_pkg::ADDR_COUNT_LOW, 8'h11);
    @(posedge i_ref_clk);
    #1;
    i_capture_pin = 1'b0;
    rd(timer_two_pkg::ADDR_RELOAD_LOW);
    chk("no capture when disabled", 8'hcd, v);
  endtask
  initial
  begin
    #(5000 * 50);
    fail_count++;
    summarize();
  end
  initial
  begin
    i_srst = 1'b1;
    i_sfr_addr = 8'h00;
    i_sfr_wdata = 8'h00;
    i_sfr_wr = 1'b0;
    i_timer_irq_enable = 1'b1;
    i_upper_byte_clock_select = 1'b0;
    i_lower_byte_clock_select = 1'b0;
    i_ext_clk = 1'b0;
    i_capture_pin = 1'b1;
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_srst = 1'b0;
    t_reset();
    t_wrap16();
    t_low16();
    t_split();
    t_sources();
    t_capture();
    summarize();
  end
endmodule
`default_nettype wire
